/* File: src/aux_io_cfg.svh */
`ifndef AUX_IO_CFG_SVH
`define AUX_IO_CFG_SVH
// ==========================================================
// register offsets (byte addresses, word index = address / 4)
`define OFS_CONFIG 8'h00
`define OFS_ACCESSORY 8'h04
`define OFS_INPUT_STATUS 8'h08
`define OFS_ANALOG_LOW 8'h0c
`define OFS_ANALOG_HIGH 8'h10
`define OFS_ROUTE 8'h14
// ==========================================================
// config field positions
`define CFG_MODE_LSB 0
`define CFG_STOP_FN_LSB 2
`define CFG_LOOP_LSB 4
`define CFG_SINGLE_BIT 6
`define CFG_RESET 32'h0000_0001
// ==========================================================
// status reply codes and thresholds
`define FIELD_OFF 8'h00
`define FIELD_ON 8'h01
`define DIGITAL_THRESHOLD 8'h1a
`define SPEED_ZERO 8'h80
`endif

/* File: src/aux_io_pkg.sv */
package aux_io_pkg;
  // ==========================================================
  // operating and function modes
  typedef enum logic [1:0] {mode_radio, mode_serial, mode_analog, mode_rsvd} op_mode_t;
  typedef enum logic [1:0] {stop_none, stop_estop, stop_invert, stop_general} stop_fn_t;
  typedef enum logic [1:0] {loop_open, loop_position, loop_speed, loop_rsvd} loop_mode_t;
  typedef enum logic [2:0] {role_unused, role_command, role_position, role_speed} role_t;
  // ==========================================================
  // bus request bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
endpackage : aux_io_pkg

/* File: src/motor_ctrl_aux_io_logic.sv */
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "aux_io_cfg.svh"
module motor_ctrl_aux_io_logic
  import aux_io_pkg::*;
#(
  parameter int ADC_W = 8
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // digital pins and radio channel levels
  input wire logic pullup_input_pin,
  input wire logic floating_input_pin,
  input wire logic stop_invert_input,
  // analog samples, 0 = 0V, full scale = 5V
  input wire logic [ADC_W-1:0] analog_in [4],
  // accessory open-drain output
  output logic accessory_out,
  output logic accessory_oe,
  // motor control effects
  output logic motor_invert,
  output logic motor_estop,
  output logic radio_ch2,
  output logic radio_ch3,
  output logic signed [ADC_W-1:0] speed_fb_one,
  output logic signed [ADC_W-1:0] speed_fb_two
);
  // ==========================================================
  // synchronisers
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic pin_pullup;
  logic pin_float;
  logic pin_stop;
  bus_req_t req;
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  // first stage read only by the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 3'h7;
      sync_b <= 3'h7;
    end else if (clk_en) begin
      sync_a <= {stop_invert_input, floating_input_pin, pullup_input_pin};
      sync_b <= sync_a;
    end
  end
  assign pin_pullup = sync_b[0];
  assign pin_float = sync_b[1];
  assign pin_stop = sync_b[2];

  // ==========================================================
  // configuration register
  logic [31:0] config_reg;
  op_mode_t op_mode;
  stop_fn_t stop_fn;
  loop_mode_t loop_mode;
  logic single_chan;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config_reg <= `CFG_RESET;
    end else if (clk_en && req.wr && req.addr == `OFS_CONFIG) begin
      config_reg <= {25'h0, req.wdata[6:0]};
    end
  end
  assign op_mode = op_mode_t'(config_reg[`CFG_MODE_LSB +: 2]);
  assign stop_fn = stop_fn_t'(config_reg[`CFG_STOP_FN_LSB +: 2]);
  assign loop_mode = loop_mode_t'(config_reg[`CFG_LOOP_LSB +: 2]);
  assign single_chan = config_reg[`CFG_SINGLE_BIT];

  // ==========================================================
  // pin roles by mode
  logic user_mode;
  logic pullup_on;
  logic float_on;
  logic stop_on;
  logic analog4_digital;
  assign user_mode = (op_mode == mode_serial) || (op_mode == mode_analog);
  // undriven line is held high by the pull-up, so high reads on
  assign pullup_on = pin_pullup;
  assign float_on = pin_float;
  // high means released: no stop, not inverted
  assign stop_on = pin_stop;
  // shared line judged by its analog level, a cleaner decision than the pin logic level
  assign analog4_digital = (analog_in[3] >= `DIGITAL_THRESHOLD);

  // ==========================================================
  // radio channel forwarding, only in radio mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      radio_ch2 <= 1'b0;
      radio_ch3 <= 1'b0;
    end else if (clk_en) begin
      radio_ch2 <= (op_mode == mode_radio) ? pin_float : 1'b0;
      radio_ch3 <= (op_mode == mode_radio) ? pin_pullup : 1'b0;
    end
  end

  // ==========================================================
  // accessory output
  logic accessory_cmd;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accessory_cmd <= 1'b0;
    end else if (clk_en && req.wr && req.addr == `OFS_ACCESSORY && op_mode == mode_serial) begin
      accessory_cmd <= req.wdata[0];
    end
  end
  // open drain: enable pulls the line low, meaning accessory on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accessory_out <= 1'b0;
      accessory_oe <= 1'b0;
    end else if (clk_en) begin
      accessory_out <= 1'b0;
      if (op_mode == mode_radio) begin
        accessory_oe <= pin_pullup;
      end else if (op_mode == mode_serial) begin
        accessory_oe <= accessory_cmd;
      end else begin
        accessory_oe <= 1'b0;
      end
    end
  end

  // ==========================================================
  // stop/invert effects
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_invert <= 1'b0;
      motor_estop <= 1'b0;
    end else if (clk_en) begin
      motor_invert <= (stop_fn == stop_invert) && !stop_on;
      motor_estop <= (stop_fn == stop_estop) && !stop_on;
    end
  end

  // ==========================================================
  // analog routing roles, three bits per input
  role_t role [4];
  role_t fb_role;
  always_comb begin
    fb_role = (loop_mode == loop_speed) ? role_speed : role_position;
    for (int i = 0; i < 4; i++) begin
      role[i] = role_unused;
    end
    if (loop_mode == loop_position || loop_mode == loop_speed) begin
      if (op_mode == mode_analog) begin
        role[0] = role_command;
        role[1] = single_chan ? role_unused : role_command;
        role[2] = fb_role;
        role[3] = single_chan ? role_unused : fb_role;
      end else begin
        role[0] = fb_role;
        role[1] = single_chan ? role_unused : fb_role;
      end
    end
  end

  // ==========================================================
  // speed feedback, mid-scale is zero speed
  logic [ADC_W-1:0] fb_one;
  logic [ADC_W-1:0] fb_two;
  assign fb_one = (op_mode == mode_analog) ? analog_in[2] : analog_in[0];
  assign fb_two = (op_mode == mode_analog) ? analog_in[3] : analog_in[1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_fb_one <= '0;
      speed_fb_two <= '0;
    end else if (clk_en && loop_mode == loop_speed) begin
      // offset binary to signed: 0V full reverse, 5V full forward
      speed_fb_one <= $signed(fb_one ^ ADC_W'(`SPEED_ZERO));
      speed_fb_two <= $signed(fb_two ^ ADC_W'(`SPEED_ZERO));
    end else if (clk_en) begin
      speed_fb_one <= '0;
      speed_fb_two <= '0;
    end
  end

  // ==========================================================
  // read mux; pull-up and floating fields meaningful in serial and analog modes only, stop field in every mode
  logic [7:0] field_one;
  logic [7:0] field_two;
  logic [7:0] field_three;
  logic [31:0] next_rdata;
  always_comb begin
    field_one = (user_mode && pullup_on) ? `FIELD_ON : `FIELD_OFF;
    if (user_mode && analog_in[3] != '0) begin
      field_one = analog4_digital ? `FIELD_ON : `FIELD_OFF;
    end
    field_two = (user_mode && float_on) ? `FIELD_ON : `FIELD_OFF;
    field_three = stop_on ? `FIELD_ON : `FIELD_OFF;
    next_rdata = 32'h0;
    case (req.addr)
      `OFS_CONFIG: next_rdata = config_reg;
      `OFS_ACCESSORY: next_rdata = {31'h0, accessory_oe};
      `OFS_INPUT_STATUS: next_rdata = {8'h00, field_one, field_two, field_three};
      `OFS_ANALOG_LOW: next_rdata = {16'h0, 8'(analog_in[0]), 8'(analog_in[1])};
      `OFS_ANALOG_HIGH: next_rdata = {16'h0, 8'(analog_in[2]), 8'(analog_in[3])};
      `OFS_ROUTE: next_rdata = {20'h0, role[3], role[2], role[1], role[0]};
      default: next_rdata = 32'h0;
    endcase
  end
  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0;
    end else if (clk_en) begin
      rdata <= req.rd ? next_rdata : 32'h0;
    end
  end
endmodule : motor_ctrl_aux_io_logic

/* File: verif/aux_switch_model.sv */
`timescale 1ns/1ps
// ==========================================================
// external switches: two lines pulled up, one left floating
module aux_switch_model (
  // clock and switch controls
  input wire logic clk,
  input wire logic [2:0] drive_en,
  input wire logic [2:0] drive_lvl,
  // lines seen by the block
  output logic pullup_pin,
  output logic floating_pin,
  output logic stop_pin
);
  logic wander = 1'b0;
  // an open floating line has no level, so it changes every cycle
  always @(posedge clk) wander <= ~wander;
  assign pullup_pin = drive_en[0] ? drive_lvl[0] : 1'b1;
  assign floating_pin = drive_en[1] ? drive_lvl[1] : wander;
  assign stop_pin = drive_en[2] ? drive_lvl[2] : 1'b1;
endmodule : aux_switch_model

/* File: verif/aux_io_sva.sv */
`timescale 1ns/1ps
// ==========================================================
// port checker, pins reach outputs two sync flops plus one
module aux_io_sva #(parameter int ADC_W = 8) (
  // clock and register port
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // pins and effects
  input wire logic pullup_input_pin,
  input wire logic floating_input_pin,
  input wire logic stop_invert_input,
  input wire logic [ADC_W-1:0] analog_in [4],
  input wire logic accessory_out,
  input wire logic accessory_oe,
  input wire logic motor_invert,
  input wire logic motor_estop,
  input wire logic radio_ch2,
  input wire logic radio_ch3,
  input wire logic signed [ADC_W-1:0] speed_fb_one
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_OD_DATA_LOW: assert property (accessory_out == 1'b0) else $error("drain data not low");
  AST_RDATA_IDLE: assert property ($past(clk_en && !rd) |-> rdata == 32'h0)
    else $error("read data outside read slot");
  AST_STATUS_CODES: assert property ($past(clk_en && rd && addr == 8'h08) |-> (rdata & 32'hfffe_fefe) == 32'h0)
    else $error("status field not 00 or 01");
  AST_STOP_FIELD: assert property ($past(clk_en && rd && addr == 8'h08) |-> rdata[0] == $past(stop_invert_input, 3))
    else $error("stop field wrong");
  AST_OPEN_NO_STOP: assert property (stop_invert_input [*3] |=> !motor_estop && !motor_invert)
    else $error("stop or invert with open line");
  // registered output lags the pin by two sync flops plus its own flop
  AST_CH3_FROM_PIN: assert property (radio_ch3 |-> $past(pullup_input_pin, 3))
    else $error("channel three not from pin");
  AST_CH2_FROM_PIN: assert property (radio_ch2 |-> $past(floating_input_pin, 3))
    else $error("channel two not from pin");
  // source is input one, or input three in analog mode, which this checker cannot see
  AST_SPEED_MID: assert property (speed_fb_one != 0 |-> (8'(speed_fb_one) == ($past(analog_in[0]) ^ 8'h80)) ||
    (8'(speed_fb_one) == ($past(analog_in[2]) ^ 8'h80)))
    else $error("speed feedback not offset");
  AST_OE_CAUSE: assert property ($rose(accessory_oe) |-> $past(wr && addr == 8'h04, 2) || $past(pullup_input_pin, 3))
    else $error("accessory on without cause");
endmodule : aux_io_sva
bind motor_ctrl_aux_io_logic aux_io_sva #(.ADC_W(ADC_W)) chk_i (.*);

/* File: verif/motor_ctrl_aux_io_logic_tb.sv */
`timescale 1ns/1ps
module motor_ctrl_aux_io_logic_tb;
  // ==========================================================
  // stimulus, switches and design
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] sw_en = 3'h0;
  logic [2:0] sw_lvl = 3'h0;
  logic [7:0] ana [4] = '{default: 8'h00};
  logic [31:0] rdata;
  logic pu, fl, st, acc_out, acc_oe, inv, estop, ch2, ch3;
  logic signed [7:0] fb1, fb2;
  int fails = 0;
  int check_count = 0;
  // half period of 25 ns gives 20 MHz
  initial forever #25 clk = ~clk;
  aux_switch_model sw (.clk(clk), .drive_en(sw_en), .drive_lvl(sw_lvl), .pullup_pin(pu), .floating_pin(fl),
    .stop_pin(st));
  motor_ctrl_aux_io_logic dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pullup_input_pin(pu), .floating_input_pin(fl), .stop_invert_input(st),
    .analog_in(ana), .accessory_out(acc_out), .accessory_oe(acc_oe), .motor_invert(inv), .motor_estop(estop),
    .radio_ch2(ch2), .radio_ch3(ch3), .speed_fb_one(fb1), .speed_fb_two(fb2));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk
  // bit 0 pull-up line, bit 1 floating line, bit 2 stop line; waits out the sync delay
  task automatic pins(input logic [2:0] en, input logic [2:0] lvl);
    @(posedge clk);
    sw_en <= en;
    sw_lvl <= lvl;
    cyc(5);
  endtask : pins
  task automatic cfg(input logic [31:0] c);
    wr_reg(8'h00, c);
    cyc(3);
  endtask : cfg
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================================
  // scenarios
  task automatic t_accessory;
    rd_chk(8'h00, 32'h1);
    rd_chk(8'h18, 32'h0);
    wr_reg(8'h04, 32'h1);
    cyc(2);
    chk(acc_oe, 1'b1);
    wr_reg(8'h04, 32'h0);
    cyc(2);
    chk(acc_oe, 1'b0);
    cfg(32'h0);
    pins(3'b011, 3'b000);
    wr_reg(8'h04, 32'h1);
    cyc(3);
    chk(acc_oe, 1'b0);
    pins(3'b011, 3'b011);
    chk({acc_out, acc_oe, ch3, ch2}, 4'b0111);
    rd_chk(8'h08, 32'h0000_0001);
    pins(3'b011, 3'b001);
    chk({acc_oe, ch3, ch2}, 3'b110);
    cfg(32'h1);
    chk({ch3, ch2}, 2'b00);
    $display("test accessory done");
  endtask : t_accessory
  task automatic t_status;
    pins(3'b010, 3'b000);
    rd_chk(8'h08, 32'h0001_0001);
    pins(3'b111, 3'b010);
    rd_chk(8'h08, 32'h0000_0100);
    @(posedge clk);
    ana[3] <= 8'h19;
    cyc(4);
    rd_chk(8'h08, 32'h0000_0100);
    @(posedge clk);
    ana[3] <= 8'h1a;
    cyc(4);
    rd_chk(8'h08, 32'h0001_0100);
    cfg(32'h5);
    chk({estop, inv}, 2'b10);
    cfg(32'h9);
    chk({estop, inv}, 2'b01);
    cfg(32'hd);
    chk({estop, inv}, 2'b00);
    rd_chk(8'h08, 32'h0001_0100);
    cfg(32'h9);
    pins(3'b010, 3'b010);
    chk({estop, inv}, 2'b00);
    $display("test status done");
  endtask : t_status
  task automatic t_analog;
    @(posedge clk);
    ana <= '{8'h11, 8'h22, 8'h33, 8'h44};
    cyc(4);
    rd_chk(8'h0c, 32'h1122);
    rd_chk(8'h10, 32'h3344);
    cfg(32'h21);
    chk({fb1, fb2}, 16'h91a2);
    wr_reg(8'h00, 32'h11);
    rd_chk(8'h14, 32'h12);
    wr_reg(8'h00, 32'h12);
    rd_chk(8'h14, 32'h489);
    wr_reg(8'h00, 32'h51);
    rd_chk(8'h14, 32'h2);
    wr_reg(8'h00, 32'h22);
    rd_chk(8'h14, 32'h6c9);
    $display("test analog done");
  endtask : t_analog
  // a write under a low enable is lost; a mid-run reset restores defaults
  task automatic t_reset_freeze;
    @(posedge clk);
    clk_en <= 1'b0;
    addr <= 8'h00;
    wdata <= 32'h2;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    clk_en <= 1'b1;
    rd_chk(8'h00, 32'h22);
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(2);
    chk({acc_out, acc_oe, inv, estop, ch2, ch3, fb1, fb2}, 22'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(8'h00, 32'h1);
    $display("test reset and freeze done");
  endtask : t_reset_freeze
  // main sequence: reset for ten cycles, then the scenarios
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_accessory();
    t_status();
    t_analog();
    t_reset_freeze();
    tally_and_finish();
  end
  // watchdog, far beyond the 155 or so cycles the scenarios need
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
endmodule : motor_ctrl_aux_io_logic_tb
